/* include/dial_pulse_defines.svh */
`ifndef DIAL_PULSE_DEFINES_SVH
`define DIAL_PULSE_DEFINES_SVH

// clock rate and derived millisecond tick
`define CLK_HZ          40_000_000
`define MS_PER_S        1000
`define TICK_CYCLES     (`CLK_HZ / `MS_PER_S)

// pulse timing in milliseconds; time-out also given in seconds
`define BREAK_MS        60
`define MAKE_MS         40
`define INTERDIGIT_MS   400
`define EOD_AFTER_MS    600
`define EOD_WAIT_MS     (`EOD_AFTER_MS - `INTERDIGIT_MS)
`define TIMEOUT_S       10
`define TIMEOUT_MS      (`TIMEOUT_S * `MS_PER_S)

// digit encoding
`define NUM_DIGITS      10
`define ZERO_DIGIT      4'h0
`define ZERO_PULSES     4'hA
`define MAX_COUNT       4
`define CNT_W           3
`define STRAP_W         (`NUM_DIGITS * `CNT_W)
`define PHASE_W         10
`define TMO_W           14

`endif

/* include/dial_pulse_pkg.sv */
package dial_pulse_pkg;
   // gray codes along break -> make -> interdigit -> end-of-digit wait
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_BREAK = 3'b001,
      ST_MAKE  = 3'b011,
      ST_IDGT  = 3'b010,
      ST_EODW  = 3'b110
   } pulse_state_t;
endpackage

/* hw/dial_pulse_release_control.sv */
// What this block does
// - each trigger gives a 60 ms break then a 40 ms make on the relay
// - relay held operated between pulses until the next trigger
// - seizure operates the relay at once; while seized only a trigger releases it
// - first dialed digit alone fixes total digit count, up to four
// - strapped count per first digit selects the total used
// - first-digit gate armed at seizure, opened by first start-write, closed by the first digit lines
// - count end-of-digit pulses; at total assert release request
// - time-out starts timing at seizure, digit or not
// - ten seconds without outpulsing fires time-out relay
// - attendant option, no digit sent: time-out stores digit zero
// - direct option: time-out releases and cuts station through
// - outpulsing restarts time-out; ten seconds again after it ends
// - digit already sent: time-out cuts through and releases, no zero
// - stored digits pulsed in dialed order at ten pulses per second
// - pretranslation release on its own output, apart from time-out
// - end-of-digit pulse 600 ms after last pulse of digit
// - 400 ms interdigit timing before digit complete
`timescale 1ns/1ps
`include "dial_pulse_defines.svh"

module dial_pulse_release_control #(
   parameter int TICK_CYCLES = `TICK_CYCLES,
   parameter int TIMEOUT_MS  = `TIMEOUT_MS
) (
   input  wire logic                  clock,
   input  wire logic                  sys_rst,
   input  wire logic                  seize,
   input  wire logic [`NUM_DIGITS-1:0] digit_lines,
   input  wire logic                  start_write,
   input  wire logic                  attendant_opt,
   input  wire logic [`STRAP_W-1:0]   count_strap,
   input  wire logic [3:0]            digit_in,
   input  wire logic                  digit_in_valid,
   output logic                       digit_in_ready,
   output logic                       pulse_relay,
   output logic                       digit_done,
   output logic                       end_of_digit,
   output logic                       pretrans_release,
   output logic                       timeout_relay,
   output logic                       cut_through_relay,
   output logic                       store_zero
);
   import dial_pulse_pkg::*;

   // pins from the interface and receiver pass two flops first
   logic                   seize_m_r, seize_s_r;
   logic [`NUM_DIGITS-1:0] dl_m_r, dl_s_r;
   always_ff @(posedge clock) begin
      seize_m_r <= seize;
      seize_s_r <= seize_m_r;
      dl_m_r    <= digit_lines;
      dl_s_r    <= dl_m_r;
   end

   // millisecond enable from a divider; seizure released acts as reset
   logic [31:0] div_r;
   wire         idle_rst = sys_rst || !seize_s_r;
   wire         tick     = (div_r == 32'(TICK_CYCLES - 1));
   always_ff @(posedge clock) begin
      if (idle_rst || tick) div_r <= '0;
      else div_r <= div_r + 32'h0000_0001;
   end

   // pulse engine registers
   pulse_state_t         state_r, state_nxt;
   logic [`PHASE_W-1:0]  phase_r;
   logic [3:0]           left_r;
   logic                 inject_r;

   // digits come from memory in dialed order; injected zero has priority
   wire       take      = (state_r == ST_IDLE) && (digit_in_valid || inject_r);
   wire [3:0] take_val  = inject_r ? `ZERO_DIGIT : digit_in;
   wire [3:0] take_cnt  = (take_val == `ZERO_DIGIT) ? `ZERO_PULSES
                                                     : take_val;
   assign digit_in_ready = (state_r == ST_IDLE) && !inject_r
                           && seize_s_r;

   // phase end conditions in milliseconds
   wire brk_end  = tick && (phase_r == `PHASE_W'(`BREAK_MS - 1));
   wire make_end = tick && (phase_r == `PHASE_W'(`MAKE_MS - 1));
   wire idgt_end = tick && (phase_r == `PHASE_W'(`INTERDIGIT_MS - 1));
   wire eodw_end = tick && (phase_r == `PHASE_W'(`EOD_WAIT_MS - 1));
   wire last_pls = (left_r == 4'h1);

   // next state: break/make cycle gives 100 ms per pulse, i.e. 10 pps
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE:  if (take) state_nxt = ST_BREAK;
         ST_BREAK: if (brk_end) state_nxt = ST_MAKE;
         ST_MAKE:  if (make_end)
                      state_nxt = last_pls ? ST_IDGT : ST_BREAK;
         ST_IDGT:  if (idgt_end) state_nxt = ST_EODW;
         ST_EODW:  if (eodw_end) state_nxt = ST_IDLE;
         default:  state_nxt = ST_IDLE;
      endcase
   end

   wire phase_clr = (state_nxt != state_r) || (state_r == ST_IDLE);

   always_ff @(posedge clock) begin
      if (idle_rst) begin
         state_r <= ST_IDLE;
         phase_r <= '0;
      end else begin
         state_r <= state_nxt;
         if (phase_clr) phase_r <= '0;
         else if (tick) phase_r <= phase_r + `PHASE_W'(1);
      end
   end

   // pulses left in the current digit
   always_ff @(posedge clock) begin
      if (idle_rst) left_r <= 4'h0;
      else if (take) left_r <= take_cnt;
      else if (state_r == ST_MAKE && make_end) left_r <= left_r - 4'h1;
   end

   // relay operated whenever seized and not in a break
   always_ff @(posedge clock) begin
      if (sys_rst) pulse_relay <= 1'b0;
      else pulse_relay <= seize_s_r && (state_nxt != ST_BREAK);
   end

   // completion strobes
   always_ff @(posedge clock) begin
      if (idle_rst) begin
         digit_done   <= 1'b0;
         end_of_digit <= 1'b0;
      end else begin
         digit_done   <= (state_r == ST_IDGT) && idgt_end;
         end_of_digit <= (state_r == ST_EODW) && eodw_end;
      end
   end

   // first-digit gate and strapped count selection
   logic               gate_armed_r, gate_open_r;
   logic               zero_pick;
   logic [`CNT_W-1:0]  total_r, eod_cnt_r;
   logic [`CNT_W-1:0]  sel_cnt;
   wire                dl_any = |dl_s_r;
   always_comb begin
      sel_cnt = '0;
      for (int i = 0; i < `NUM_DIGITS; i++)
         if (dl_s_r[i]) sel_cnt = count_strap[i*`CNT_W +: `CNT_W];
   end
   wire [`CNT_W-1:0] sel_lim = (sel_cnt > `CNT_W'(`MAX_COUNT))
                               ? `CNT_W'(`MAX_COUNT) : sel_cnt;

   // a stored attendant zero picks its own total when no start-write
   // came first, so the zero still releases through pretranslation
   wire [`CNT_W-1:0] zero_cnt = count_strap[`CNT_W-1:0];
   wire [`CNT_W-1:0] zero_lim = (zero_cnt > `CNT_W'(`MAX_COUNT))
                                ? `CNT_W'(`MAX_COUNT) : zero_cnt;

   always_ff @(posedge clock) begin
      if (idle_rst) begin
         gate_armed_r <= 1'b1;
         gate_open_r  <= 1'b0;
         total_r      <= '0;
      end else begin
         if (gate_armed_r && start_write) begin
            gate_armed_r <= 1'b0;
            gate_open_r  <= 1'b1;
         end else if (gate_open_r && dl_any) begin
            gate_open_r  <= 1'b0;
            total_r      <= sel_lim;
         end else if (zero_pick) begin
            gate_armed_r <= 1'b0;
            total_r      <= zero_lim;
         end
      end
   end

   // end-of-digit counting toward pretranslated total
   wire hit = (total_r != '0) && (eod_cnt_r >= total_r);
   always_ff @(posedge clock) begin
      if (idle_rst) begin
         eod_cnt_r        <= '0;
         pretrans_release <= 1'b0;
      end else begin
         if (end_of_digit && !hit) eod_cnt_r <= eod_cnt_r + `CNT_W'(1);
         pretrans_release <= hit;
      end
   end

   // time-out: counts from seizure, held at zero while outpulsing
   logic [`TMO_W-1:0] tmo_r;
   logic              sent_r, fired_r;
   wire               busy = (state_r != ST_IDLE) || take || inject_r;
   wire               fire = tick && !busy && !fired_r
                             && (tmo_r == `TMO_W'(TIMEOUT_MS - 1));
   always_ff @(posedge clock) begin
      if (idle_rst || busy) tmo_r <= '0;
      else if (tick && !fired_r) tmo_r <= tmo_r + `TMO_W'(1);
   end

   // once a digit has gone out, time-out never dials zero
   always_ff @(posedge clock) begin
      if (idle_rst) sent_r <= 1'b0;
      else if (end_of_digit) sent_r <= 1'b1;
   end

   // time-out actions; fired holds until seizure ends
   wire zero_path = attendant_opt && !sent_r;
   assign zero_pick = fire && zero_path && gate_armed_r;
   always_ff @(posedge clock) begin
      if (idle_rst) begin
         fired_r           <= 1'b0;
         timeout_relay     <= 1'b0;
         cut_through_relay <= 1'b0;
         inject_r          <= 1'b0;
         store_zero        <= 1'b0;
      end else begin
         store_zero <= fire && zero_path;
         if (fire) begin
            fired_r       <= 1'b1;
            timeout_relay <= 1'b1;
            if (zero_path) inject_r <= 1'b1;
            else cut_through_relay <= 1'b1;
         end else if (take) begin
            inject_r <= 1'b0;
         end
      end
   end

   // an injected zero digit is pulsed and counted like a dialed one, so
   // the strapped count for zero releases through pretranslation

   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   AST_BREAK_OPENS: assert property (
      (state_r == ST_BREAK && seize_s_r && !brk_end) |=> !pulse_relay)
      else $error("relay not broken during break");
   AST_BREAK_TO_MAKE: assert property (
      (state_r == ST_BREAK && brk_end && seize_s_r) |=> state_r == ST_MAKE)
      else $error("break did not end in make");
   AST_MAKE_HELD: assert property (
      (state_r == ST_IDLE && seize_s_r && !take) |=> pulse_relay)
      else $error("relay not held operated while idle");
   AST_SEIZE_OPERATES: assert property (
      ($rose(seize_s_r) && state_r == ST_IDLE) |=> pulse_relay)
      else $error("seizure did not operate relay");
   AST_GATE_ONCE: assert property (
      (!gate_armed_r && seize_s_r) |=> !gate_armed_r)
      else $error("first-digit gate rearmed while seized");
   AST_PRETRANS: assert property (
      (hit && seize_s_r) |=> pretrans_release)
      else $error("release not raised at digit total");
   AST_TMO_FIRE: assert property (
      (fire && seize_s_r) |=> timeout_relay && fired_r)
      else $error("time-out relay not operated");
   AST_TMO_RESTART: assert property (
      (busy && seize_s_r) |=> tmo_r == '0)
      else $error("time-out not restarted by outpulsing");
   AST_ZERO_STORE: assert property (
      (fire && zero_path && seize_s_r) |=> inject_r && !cut_through_relay)
      else $error("zero not stored on attendant time-out");
   AST_CUT_THROUGH: assert property (
      (fire && !zero_path && seize_s_r) |=> cut_through_relay && !inject_r)
      else $error("time-out did not cut through");
   AST_EOD_PULSE: assert property (
      (state_r == ST_EODW && eodw_end && seize_s_r)
      |=> end_of_digit ##1 !end_of_digit)
      else $error("end-of-digit pulse missing");
   AST_ZERO_TEN: assert property (
      (take && take_val == `ZERO_DIGIT && seize_s_r) |=> left_r == `ZERO_PULSES)
      else $error("zero digit not ten pulses");

   // engine sequencing between pulses and digits
   AST_MAKE_NEXT: assert property (
      (state_r == ST_MAKE && make_end && !last_pls && seize_s_r)
      |=> state_r == ST_BREAK && !pulse_relay)
      else $error("next pulse did not follow make");
   AST_MAKE_TO_IDGT: assert property (
      (state_r == ST_MAKE && make_end && last_pls && seize_s_r)
      |=> state_r == ST_IDGT && pulse_relay)
      else $error("last make did not start interdigit");
   AST_DIGIT_DONE: assert property (
      (state_r == ST_IDGT && idgt_end && seize_s_r)
      |=> digit_done && state_r == ST_EODW)
      else $error("digit done not raised after interdigit");
   AST_EOD_IDLE: assert property (
      (state_r == ST_EODW && eodw_end && seize_s_r) |=> state_r == ST_IDLE)
      else $error("engine not idle after end of digit");
   AST_LEFT_VALUE: assert property (
      (take && take_val != `ZERO_DIGIT && seize_s_r)
      |=> left_r == $past(take_val))
      else $error("pulse count differs from digit value");

   // time-out and release leads
   AST_TMO_COUNT: assert property (
      (tick && !busy && !fired_r && seize_s_r)
      |=> tmo_r == $past(tmo_r) + `TMO_W'(1))
      else $error("time-out not counting while seized");
   AST_ZERO_TOTAL: assert property (
      (zero_pick && !start_write && seize_s_r)
      |=> total_r == zero_lim && !gate_armed_r)
      else $error("stored zero did not select its total");
   AST_SENT_NO_ZERO: assert property (
      (fire && sent_r && seize_s_r) |=> !store_zero && !inject_r)
      else $error("zero stored after a digit was sent");
   AST_CUT_ONLY_TMO: assert property (
      (!fire && !fired_r && seize_s_r) |=> !cut_through_relay)
      else $error("cut-through without time-out");
   AST_PRE_ONLY_HIT: assert property (
      (!hit && seize_s_r) |=> !pretrans_release)
      else $error("release request without digit total");
endmodule

/* sim/dial_repeat_model.sv */
`timescale 1ns/1ps
// far side: seizes on call, frees the converter some cycles after a
// release request; once freed it stays off until the call ends
module dial_repeat_model (
   input  wire logic       clock,
   input  wire logic       sys_rst,
   input  wire logic       call,
   input  wire logic [7:0] release_delay,
   input  wire logic       pretrans_release,
   input  wire logic       cut_through_relay,
   output logic            seize
);
   logic [7:0] hold_r;
   // either release lead frees it, slowly or promptly
   always_ff @(posedge clock) begin
      if (sys_rst || !call) begin
         seize <= 1'b0;
         hold_r <= 8'h00;
      end else if (pretrans_release || cut_through_relay) begin
         hold_r <= hold_r + 8'h01;
         if (hold_r == release_delay) begin
            seize <= 1'b0;
         end
      end else if (hold_r == 8'h00) begin
         seize <= 1'b1;
      end
   end
endmodule

/* sim/dial_pulse_release_control_tb_top.sv */
`timescale 1ns/1ps
`include "dial_pulse_defines.svh"
module dial_pulse_release_control_tb_top;
   // short tick and time-out keep the run small: 1 ms is 4 cycles
   localparam int TICK = 4;
   logic                   clock = 1'b0;
   logic                   sys_rst = 1'b1;
   logic                   call = 1'b0;
   logic [`NUM_DIGITS-1:0] digit_lines = '0;
   logic                   start_write = 1'b0;
   logic                   attendant_opt = 1'b0;
   logic [`STRAP_W-1:0]    count_strap = '0;
   logic [3:0]             digit_in = 4'h0;
   logic                   digit_in_valid = 1'b0;
   logic [7:0]             release_delay = 8'h00;
   logic                   seize, digit_in_ready, pulse_relay, end_of_digit;
   logic                   pretrans_release, timeout_relay, store_zero;
   logic                   cut_through_relay, prev_relay, digit_done;
   logic                   saw_pre, saw_cut, saw_to;
   logic [31:0]            lfsr = 32'h290a_8fb4;
   int miscompares = 0;
   int comparisons = 0;
   int cyc = 0;
   int t_fall, t_rise, t_to, t_call, n_brk, n_eod, n_zero, n_bad;
   int t_dd, n_gap;

   always #12.5 clock = ~clock;

   dial_pulse_release_control #(.TICK_CYCLES(TICK), .TIMEOUT_MS(20)) u_dut (
      .clock(clock), .sys_rst(sys_rst), .seize(seize),
      .digit_lines(digit_lines), .start_write(start_write),
      .attendant_opt(attendant_opt), .count_strap(count_strap),
      .digit_in(digit_in), .digit_in_valid(digit_in_valid),
      .digit_in_ready(digit_in_ready), .pulse_relay(pulse_relay),
      .digit_done(digit_done), .end_of_digit(end_of_digit),
      .pretrans_release(pretrans_release), .timeout_relay(timeout_relay),
      .cut_through_relay(cut_through_relay), .store_zero(store_zero));

   dial_repeat_model u_far (
      .clock(clock), .sys_rst(sys_rst), .call(call),
      .release_delay(release_delay), .pretrans_release(pretrans_release),
      .cut_through_relay(cut_through_relay), .seize(seize));

   function automatic logic [31:0] nxt(input logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c1_1db7 : 32'h0000_0000);
   endfunction

   // divider phase is free, so a ms step may be up to one ms short
   function automatic bit off(input int len, input int ms);
      return (len - ms * TICK > 5) || (ms * TICK - len > 5);
   endfunction

   // relay edges timed here; gaps over 1000 cycles are interdigit
   always @(posedge clock) begin
      cyc = cyc + 1;
      if (prev_relay === 1'b1 && pulse_relay === 1'b0 && seize) begin
         n_brk = n_brk + 1;
         if (cyc - t_rise < 1000 && off(cyc - t_rise, `MAKE_MS)) n_bad++;
         t_fall = cyc;
      end
      if (prev_relay === 1'b0 && pulse_relay === 1'b1 && cyc - t_fall < 1000)
      begin
         if (off(cyc - t_fall, `BREAK_MS)) n_bad++;
         t_rise = cyc;
      end
      // relay must be operated whenever a digit completes
      if (end_of_digit === 1'b1) n_eod += (pulse_relay === 1'b1) ? 1 : 100;
      // digit strobes keep their spacing from the last make
      if (digit_done === 1'b1) begin
         if (cyc - t_rise != (`MAKE_MS + `INTERDIGIT_MS) * TICK) n_gap++;
         t_dd = cyc;
      end
      if (end_of_digit === 1'b1
          && cyc - t_dd != (`EOD_AFTER_MS - `INTERDIGIT_MS) * TICK) n_gap++;
      if (store_zero === 1'b1) n_zero++;
      if (pretrans_release === 1'b1) saw_pre = 1'b1;
      if (cut_through_relay === 1'b1) saw_cut = 1'b1;
      if (timeout_relay === 1'b1 && !saw_to) t_to = cyc;
      if (timeout_relay === 1'b1) saw_to = 1'b1;
      prev_relay = pulse_relay;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic setup(input logic [`STRAP_W-1:0] st, input logic att);
      @(posedge clock);
      // let the last call's release leads clear before a new seizure
      call <= 1'b0;
      tick(8);
      count_strap <= st;
      attendant_opt <= att;
      release_delay <= lfsr[30] ? 8'h02 : 8'h30;
      call <= 1'b1;
      @(negedge clock);
      {n_brk, n_eod, n_zero, n_bad, n_gap, saw_pre, saw_cut, saw_to} = '0;
      t_fall = -100000;
      t_rise = -100000;
      t_call = cyc;
   endtask

   task automatic wait_out(input string name);
      int w;
      w = 0;
      while (!(saw_pre || saw_cut) && w < 9000) begin
         @(negedge clock);
         w++;
      end
      tick(4);
      $display("test %s done", name);
   endtask

   task automatic run_idle(input logic att);
      lfsr = nxt(lfsr);
      setup({lfsr[29:3], 3'h1}, att);
      wait_out("time-out");
      check(saw_to, 1'b1);
      check(t_to - t_call >= 76 && t_to - t_call <= 96, 1'b1);
      check(n_zero, att);
      check(n_brk, att ? 10 : 0);
      check(saw_pre, att);
      check(saw_cut, !att);
      check(n_gap, 0);
      call <= 1'b0;
   endtask

   task automatic run_call(input logic [3:0] first);
      logic [2:0] s;
      logic [3:0] d;
      int tot, exp_brk, k, w;
      lfsr = nxt(lfsr);
      s = lfsr[3 * first +: 3];
      tot = (s > 3'h4) ? 4 : int'(s);
      exp_brk = 0;
      setup(lfsr[29:0], lfsr[31]);
      tick(5);
      check(pulse_relay, 1'b1);
      // a second start-write with another digit must not move the total
      for (k = 0; k < 2; k++) begin
         @(posedge clock);
         start_write <= 1'b1;
         digit_lines <= 10'h001 << ((first + k) % 10);
         tick(1);
         start_write <= 1'b0;
         tick(3);
         digit_lines <= '0;
      end
      for (k = 0; k < ((tot == 0) ? 1 : tot); k++) begin
         lfsr = nxt(lfsr);
         d = (k == 0) ? first : {2'b00, lfsr[1:0]} + 4'h1;
         exp_brk += (d == 4'h0) ? 10 : int'(d);
         @(posedge clock);
         digit_in <= d;
         digit_in_valid <= 1'b1;
         w = 0;
         @(negedge clock);
         while (digit_in_ready !== 1'b1 && w < 9000) begin
            @(negedge clock);
            w++;
         end
         @(posedge clock);
         digit_in_valid <= 1'b0;
      end
      wait_out("call");
      check(n_brk, exp_brk);
      check(n_eod, (tot == 0) ? 1 : tot);
      check(saw_pre, tot != 0);
      check(saw_cut, tot == 0);
      check(n_zero, 0);
      check(n_bad, 0);
      check(n_gap, 0);
      call <= 1'b0;
   endtask

   task automatic give_verdict();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      tick(3);
      sys_rst <= 1'b0;
      tick(2);
      run_idle(1'b0);
      run_idle(1'b1);
      run_call(4'h0);
      repeat (2) begin
         lfsr = nxt(lfsr);
         run_call(lfsr[3:0] % 4'ha);
      end
      give_verdict();
   end

   // the full plan needs far less than this; a hang ends here
   initial begin
      tick(90000);
      miscompares++;
      give_verdict();
   end
endmodule
